// ### rtl/eeprom_access_params.svh
// register map, field positions and timing constants of the eeprom access controller
//
// Contract
// - unused address high bits and control bits 7..6 always read zero
// - a 9-bit byte address spans two registers, bytes addressed linearly from zero
// - data register holds the byte to program, or receives the byte read
// - mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved
// - mode bits ignore writes while the write strobe is set
// - reset clears mode bits to 00 unless programming is still running
// - ready interrupt needs its enable and the global interrupt enable
// - ready interrupt asserted while strobe clear, never during programming; the code also holds it off while flash self-programming is active
// - write strobe starts programming only within four cycles of master enable
// - hardware clears master write enable four cycles after software sets it
// - no eeprom programming while flash self-programming is active
// - write strobe stays set during programming, hardware clears it when done
// - setting the write strobe stalls the cpu for two cycles
// - read strobe fetches the addressed byte into the data register at once
// - a read stalls the cpu for four cycles
// - while writing, reads are blocked and the address cannot change
// - programming time counted in calibrated rc oscillator cycles, 26368
// - a write under way at reset still completes
`ifndef EEPROM_ACCESS_PARAMS_SVH
`define EEPROM_ACCESS_PARAMS_SVH

`define EE_OFS_ADDR_LO   6'h21
`define EE_OFS_ADDR_HI   6'h22
`define EE_OFS_DATA      6'h23
`define EE_OFS_CTRL      6'h24

`define EE_BIT_READ      0
`define EE_BIT_WRITE     1
`define EE_BIT_MWE       2
`define EE_BIT_RIE       3
`define EE_BIT_MODE_LO   4
`define EE_BIT_MODE_HI   5

`define EE_MODE_ATOMIC   2'h0
`define EE_MODE_ERASE    2'h1
`define EE_MODE_WRITE    2'h2
`define EE_MODE_RSVD     2'h3
`define EE_RST_MODE      2'h0
`define EE_ERASED_BYTE   8'hff

`define EE_MWE_CYC       3'h4
`define EE_WR_STALL_CYC  3'h2
`define EE_RD_STALL_CYC  3'h4

`define EE_MCLK_NS       10
`define EE_T_ATOMIC_US   3400
`define EE_T_SPLIT_US    1800
`define EE_RC_WR_CYCLES  26368
`define EE_T_RC_WR_NS    3300000
`define EE_RC_DIV        ((`EE_T_RC_WR_NS / `EE_RC_WR_CYCLES) / `EE_MCLK_NS)
`define EE_SPLIT_TICKS   ((`EE_RC_WR_CYCLES * `EE_T_SPLIT_US) / `EE_T_ATOMIC_US)

`endif

// ### rtl/eeprom_access_pkg.sv
// types shared by the eeprom access controller
package eeprom_access_pkg;
  typedef logic [1:0] prog_mode_t;
  typedef enum logic {OP_IDLE, OP_PROG} op_state_t;
endpackage : eeprom_access_pkg

// ### rtl/eeprom_array.sv
// byte array standing in for the eeprom cells, registered read data
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
  parameter int DEPTH  = 512,
  parameter int ADDR_W = 9
) (
  // clock
  input  wire logic              mclk,
  // access port
  input  wire logic              rd_en,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata_q
);
  logic [7:0] cells [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      cells[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rdata_q <= cells[addr];
    end
  end
endmodule : eeprom_array
`default_nettype wire

// ### rtl/eeprom_access_controller.sv
// eeprom access controller: i/o registers, write timing, cpu stall and ready request
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_params.svh"
module eeprom_access_controller
  import eeprom_access_pkg::*;
#(
  parameter int DEPTH        = 512,
  parameter int ADDR_W       = 9,
  parameter int TICK_W       = 15,
  parameter int RC_DIV       = `EE_RC_DIV,
  parameter int ATOMIC_TICKS = `EE_RC_WR_CYCLES,
  parameter int SPLIT_TICKS  = `EE_SPLIT_TICKS
) (
  // clock and resets
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       por_n,
  // cpu i/o space access
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata_q,
  // cpu side status
  input  wire logic       global_irq_enable,
  input  wire logic       flash_selfprog_active,
  output logic            cpu_stall,
  output logic            ready_irq_q
);
  localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'(DEPTH - 1);

  op_state_t         state_q;
  prog_mode_t        prog_mode_field_q;
  prog_mode_t        op_mode_q;
  logic              ready_irq_enable_q;
  logic [2:0]        mwe_cnt_q;
  logic [2:0]        stall_cnt_q;
  logic [ADDR_W-1:0] eeprom_byte_address_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [7:0]        eeprom_data_byte_q;
  logic [7:0]        op_data_q;
  logic [7:0]        old_byte_q;
  logic              old_pend_q;
  logic              rd_pend_q;
  logic [TICK_W-1:0] ticks_q;
  logic [7:0]        rc_div_q;
  logic              rc_tick;
  logic              ctrl_wr;
  logic              start;
  logic              rd_go;
  logic              commit;
  logic              busy;
  logic              master_write_enable;
  logic [7:0]        mem_rdata;
  logic [7:0]        mem_wdata;
  logic [ADDR_W-1:0] mem_addr;

  assign busy                = (state_q == OP_PROG);
  assign master_write_enable = (mwe_cnt_q != 3'h0);
  assign ctrl_wr             = io_wr && (io_addr == `EE_OFS_CTRL);
  // a strobe written without a live master enable, or against a busy array, is dropped
  assign start = ctrl_wr && io_wdata[`EE_BIT_WRITE] && master_write_enable
              && !busy && !flash_selfprog_active
              && (prog_mode_field_q != `EE_MODE_RSVD);
  assign rd_go  = ctrl_wr && io_wdata[`EE_BIT_READ] && !busy && !start;
  assign commit = busy && rc_tick && (ticks_q == '0);
  assign cpu_stall = (stall_cnt_q != 3'h0);

  // free running divider standing in for the calibrated rc oscillator
  assign rc_tick = (rc_div_q == 8'(RC_DIV - 1));
  always_ff @(posedge mclk) begin
    if (!por_n || rc_tick) begin
      rc_div_q <= 8'h00;
    end else begin
      rc_div_q <= rc_div_q + 8'h01;
    end
  end

  // programming sequencer; system reset does not abort a running write
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      state_q   <= OP_IDLE;
      ticks_q   <= '0;
      op_mode_q <= `EE_MODE_ATOMIC;
      op_addr_q <= '0;
      op_data_q <= 8'h00;
    end else begin
      case (state_q)
        OP_IDLE: begin
          if (start && rst_n) begin
            state_q   <= OP_PROG;
            op_mode_q <= prog_mode_field_q;
            op_addr_q <= eeprom_byte_address_q;
            op_data_q <= eeprom_data_byte_q;
            if (prog_mode_field_q == `EE_MODE_ATOMIC) begin
              ticks_q <= TICK_W'(ATOMIC_TICKS - 1);
            end else begin
              ticks_q <= TICK_W'(SPLIT_TICKS - 1);
            end
          end
        end
        OP_PROG: begin
          if (commit) begin
            state_q <= OP_IDLE;
          end else if (rc_tick) begin
            ticks_q <= ticks_q - TICK_W'(1);
          end
        end
        default: state_q <= OP_IDLE;
      endcase
    end
  end

  // old contents are needed for write-only mode, which can only clear bits
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      old_pend_q <= 1'b0;
      old_byte_q <= 8'h00;
    end else begin
      old_pend_q <= start && rst_n;
      if (old_pend_q) begin
        old_byte_q <= mem_rdata;
      end
    end
  end

  always_comb begin
    mem_wdata = op_data_q;
    if (op_mode_q == `EE_MODE_ERASE) begin
      mem_wdata = `EE_ERASED_BYTE;
    end else if (op_mode_q == `EE_MODE_WRITE) begin
      mem_wdata = old_byte_q & op_data_q;
    end
  end
  assign mem_addr = busy ? op_addr_q : eeprom_byte_address_q;

  eeprom_array #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) i_eeprom_array (
    .mclk    (mclk),
    .rd_en   ((rd_go || start) && rst_n),
    .wr_en   (commit),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // mode bits hold through a system reset that lands during programming; power-on reset clears them
  always_ff @(posedge mclk) begin
    if (!por_n || (!rst_n && !busy)) begin
      prog_mode_field_q <= `EE_RST_MODE;
    end else if (rst_n && ctrl_wr && !busy) begin
      prog_mode_field_q <= io_wdata[`EE_BIT_MODE_HI:`EE_BIT_MODE_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (!por_n || !rst_n) begin
      ready_irq_enable_q <= 1'b0;
      mwe_cnt_q          <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        ready_irq_enable_q <= io_wdata[`EE_BIT_RIE];
      end
      if (ctrl_wr && io_wdata[`EE_BIT_MWE]) begin
        mwe_cnt_q <= `EE_MWE_CYC;
      end else if (master_write_enable) begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!por_n || !rst_n) begin
      stall_cnt_q <= 3'h0;
    end else if (start) begin
      stall_cnt_q <= `EE_WR_STALL_CYC;
    end else if (rd_go) begin
      stall_cnt_q <= `EE_RD_STALL_CYC;
    end else if (cpu_stall) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end
  end

  // address: cleared to zero by power-on reset only, kept through system reset; frozen while busy
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      eeprom_byte_address_q <= '0;
    end else if (io_wr && !busy) begin
      if (io_addr == `EE_OFS_ADDR_LO) begin
        eeprom_byte_address_q[7:0] <= io_wdata & ADDR_MASK[7:0];
      end else if (io_addr == `EE_OFS_ADDR_HI) begin
        eeprom_byte_address_q[ADDR_W-1:8] <= io_wdata[ADDR_W-9:0] & ADDR_MASK[ADDR_W-1:8];
      end
    end
  end

  // fetched byte lands two edges after the strobe, well inside the stall
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      rd_pend_q          <= 1'b0;
      eeprom_data_byte_q <= 8'h00;
    end else begin
      rd_pend_q <= rd_go && rst_n;
      if (rd_pend_q) begin
        eeprom_data_byte_q <= mem_rdata;
      end else if (io_wr && (io_addr == `EE_OFS_DATA)) begin
        eeprom_data_byte_q <= io_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!por_n || !rst_n) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == `EE_OFS_ADDR_LO) begin
        io_rdata_q <= eeprom_byte_address_q[7:0];
      end else if (io_addr == `EE_OFS_ADDR_HI) begin
        io_rdata_q <= 8'(eeprom_byte_address_q[ADDR_W-1:8]);
      end else if (io_addr == `EE_OFS_DATA) begin
        io_rdata_q <= eeprom_data_byte_q;
      end else if (io_addr == `EE_OFS_CTRL) begin
        io_rdata_q <= {2'b00, prog_mode_field_q, ready_irq_enable_q,
                       master_write_enable, busy, 1'b0};
      end else begin
        io_rdata_q <= 8'h00;
      end
    end
  end

  // level request, held while both enables are set, the array is idle and flash self-programming is not active
  always_ff @(posedge mclk) begin
    if (!por_n || !rst_n) begin
      ready_irq_q <= 1'b0;
    end else begin
      ready_irq_q <= ready_irq_enable_q && global_irq_enable
                  && !busy && !start && !flash_selfprog_active;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !por_n);

  property p_reserved_zero;
    io_rd && io_addr == `EE_OFS_ADDR_HI |=> io_rdata_q[7:1] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_mode_time;
    start |=> ticks_q == ((op_mode_q == `EE_MODE_ATOMIC) ? TICK_W'(ATOMIC_TICKS - 1)
                                                        : TICK_W'(SPLIT_TICKS - 1));
  endproperty
  a_mode_time: assert property (p_mode_time) else $error("wrong programming time");

  property p_mode_locked;
    busy && ctrl_wr |=> $stable(prog_mode_field_q);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed while busy");

  property p_irq_quiet;
    busy |=> !ready_irq_q;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("ready request during write");

  property p_irq_gate;
    ready_irq_q |-> $past(ready_irq_enable_q) && $past(global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ready request not enabled");

  property p_start_needs_mwe;
    $rose(busy) |-> $past(master_write_enable) && !$past(flash_selfprog_active);
  endproperty
  a_start_needs_mwe: assert property (p_start_needs_mwe) else $error("start without master");

  property p_mwe_timeout;
    $rose(master_write_enable) ##0 (!(ctrl_wr && io_wdata[`EE_BIT_MWE]))[*4]
      |=> !master_write_enable;
  endproperty
  a_mwe_timeout: assert property (p_mwe_timeout) else $error("master enable not cleared");

  property p_wr_stall;
    $rose(busy) |-> cpu_stall[*2] ##1 !cpu_stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");

  property p_rd_stall;
    rd_go |=> cpu_stall[*4] ##1 !cpu_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");

  property p_rd_data;
    rd_go |-> ##2 eeprom_data_byte_q == mem_rdata;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read byte not loaded");

  property p_addr_frozen;
    busy |=> $stable(eeprom_byte_address_q) && !rd_pend_q;
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address moved during write");

  property p_busy_holds;
    busy && !(rc_tick && ticks_q == '0) |=> busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("strobe dropped early");

  c_atomic: cover property (start && prog_mode_field_q == `EE_MODE_ATOMIC);
  c_erase:  cover property (start && prog_mode_field_q == `EE_MODE_ERASE);
  c_read:   cover property (rd_go ##2 rd_pend_q == 1'b0);
  c_mwe_to: cover property ($fell(master_write_enable) && !busy);
endmodule : eeprom_access_controller
`default_nettype wire

// ### testbench/cpu_io_model.sv
// cpu core model issuing i/o reads and writes to the eeprom access controller
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_params.svh"
module cpu_io_model (
  // clock
  input  wire logic       mclk,
  // i/o space access
  output logic      [5:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata_q,
  // status
  input  wire logic       cpu_stall,
  input  wire logic       flash_selfprog_active,
  output logic            hang
);
  initial begin
    io_addr  = 6'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
    hang     = 1'b0;
  end

  // a stalled cpu issues nothing, so every access first waits out cpu_stall
  task automatic slot();
    int n;
    n = 0;
    @(negedge mclk);
    while (cpu_stall !== 1'b0 && n < 16) begin
      @(negedge mclk);
      n++;
    end
    if (n == 16) hang = 1'b1;
  endtask : slot

  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    slot();
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge mclk);
    io_wr    = 1'b0;
    // released lines show the inverse, not the last value
    io_wdata = ~d;
    io_addr  = ~a;
  endtask : io_write

  task automatic io_read(input logic [5:0] a, output logic [7:0] d);
    slot();
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge mclk);
    io_rd   = 1'b0;
    io_addr = ~a;
    d       = io_rdata_q;
  endtask : io_read

  task automatic wait_idle();
    logic [7:0] v;
    int         n;
    n = 0;
    v = 8'hff;
    while (flash_selfprog_active !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    while (v[`EE_BIT_WRITE] !== 1'b0 && n < 200) begin
      io_read(`EE_OFS_CTRL, v);
      n++;
    end
    if (n >= 200) hang = 1'b1;
  endtask : wait_idle

  task automatic ee_store(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
    wait_idle();
    io_write(`EE_OFS_ADDR_HI, {7'h00, a[8]});
    io_write(`EE_OFS_ADDR_LO, a[7:0]);
    io_write(`EE_OFS_DATA, d);
    io_write(`EE_OFS_CTRL, {2'h0, m, 4'h4});
    io_write(`EE_OFS_CTRL, {2'h0, m, 4'h2});
  endtask : ee_store

  task automatic ee_fetch(input logic [8:0] a, output logic [7:0] d);
    wait_idle();
    io_write(`EE_OFS_ADDR_HI, {7'h00, a[8]});
    io_write(`EE_OFS_ADDR_LO, a[7:0]);
    io_write(`EE_OFS_CTRL, 8'h01);
    io_read(`EE_OFS_DATA, d);
  endtask : ee_fetch
endmodule : cpu_io_model
`default_nettype wire

// ### testbench/eeprom_access_controller_bench.sv
// self-checking bench for the eeprom access controller
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_params.svh"
module eeprom_access_controller_bench import eeprom_access_pkg::*; ;
  localparam logic [5:0] CTRL = `EE_OFS_CTRL;
  localparam logic [5:0] ALO  = `EE_OFS_ADDR_LO;
  localparam logic [5:0] AHI  = `EE_OFS_ADDR_HI;
  localparam logic [5:0] DATA = `EE_OFS_DATA;
  logic       mclk, rst_n, por_n, glb_ie, flash_busy, cpu_stall, ready_irq_q;
  logic       io_wr, io_rd, hang;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata_q, v;
  int         errors, checked, run, last_run;
  logic [1:0] md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [7:0] dv [4] = '{8'h00, 8'h5a, 8'h00, 8'h81};
  logic [7:0] ev [4] = '{8'hff, 8'h5a, 8'h5a, 8'h81};

  eeprom_access_controller #(.RC_DIV(1), .ATOMIC_TICKS(20), .SPLIT_TICKS(10))
    i_eeprom_access_controller (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_q(io_rdata_q), .global_irq_enable(glb_ie),
    .flash_selfprog_active(flash_busy), .cpu_stall(cpu_stall), .ready_irq_q(ready_irq_q));

  cpu_io_model i_cpu_io_model (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .cpu_stall(cpu_stall),
    .flash_selfprog_active(flash_busy), .hang(hang));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // length of the most recent stall run, counted at falling edges
  always @(negedge mclk) begin
    if (cpu_stall === 1'b1) run++;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  always @(posedge hang) begin
    errors++;
    summarize();
  end

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_cnt(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_cnt

  task automatic expect_reg(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    i_cpu_io_model.io_read(a, r);
    check_byte(what, exp, r);
  endtask : expect_reg

  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask : gap

  initial begin
    {rst_n, por_n, glb_ie, flash_busy} = 4'h0;
    errors = 0;
    checked = 0;
    run = 0;
    last_run = 0;
    gap(4);
    rst_n = 1'b1;
    por_n = 1'b1;
    expect_reg("ctrl after reset", CTRL, 8'h00);
    i_cpu_io_model.io_write(AHI, 8'hff);
    expect_reg("addr high", AHI, 8'h01);
    i_cpu_io_model.io_write(CTRL, 8'hfe);
    expect_reg("ctrl top bits", CTRL, 8'h3c);
    i_cpu_io_model.io_write(CTRL, 8'h00);
    expect_reg("unmapped", 6'h20, 8'h00);
    $display("test registers done");
    // global interrupts stay off through the write sequences
    i_cpu_io_model.ee_store(9'h1a5, 8'h3c, `EE_MODE_ATOMIC);
    gap(3);
    check_cnt("write stall", 2, last_run);
    expect_reg("busy ctrl", CTRL, 8'h02);
    i_cpu_io_model.io_write(ALO, 8'h00);
    i_cpu_io_model.io_write(CTRL, 8'h31);
    expect_reg("mode locked", CTRL, 8'h02);
    i_cpu_io_model.wait_idle();
    expect_reg("addr held", ALO, 8'ha5);
    i_cpu_io_model.ee_fetch(9'h1a5, v);
    check_byte("read back", 8'h3c, v);
    check_cnt("read stall", 4, last_run);
    $display("test write done");
    for (int i = 0; i < 4; i++) begin
      i_cpu_io_model.ee_store(9'h1a5, dv[i], md[i]);
      gap(4);
      if (md[i] == `EE_MODE_RSVD) expect_reg("reserved idle", CTRL, 8'h30);
      i_cpu_io_model.ee_fetch(9'h1a5, v);
      check_byte("mode result", ev[i], v);
    end
    $display("test modes done");
    i_cpu_io_model.io_write(CTRL, 8'h04);
    expect_reg("master live", CTRL, 8'h04);
    gap(6);
    expect_reg("master expired", CTRL, 8'h00);
    i_cpu_io_model.io_write(DATA, 8'h77);
    i_cpu_io_model.io_write(CTRL, 8'h02);
    expect_reg("late strobe", CTRL, 8'h00);
    flash_busy = 1'b1;
    i_cpu_io_model.io_write(CTRL, 8'h04);
    i_cpu_io_model.io_write(CTRL, 8'h02);
    expect_reg("flash busy strobe", CTRL, 8'h04);
    flash_busy = 1'b0;
    gap(4);
    i_cpu_io_model.ee_fetch(9'h1a5, v);
    check_byte("array unchanged", 8'h81, v);
    $display("test refusals done");
    glb_ie = 1'b1;
    i_cpu_io_model.io_write(CTRL, 8'h08);
    gap(3);
    check_byte("irq idle", 8'h01, {7'h00, ready_irq_q});
    i_cpu_io_model.io_write(CTRL, 8'h0c);
    i_cpu_io_model.io_write(CTRL, 8'h0a);
    gap(2);
    check_byte("irq busy", 8'h00, {7'h00, ready_irq_q});
    i_cpu_io_model.wait_idle();
    gap(3);
    check_byte("irq done", 8'h01, {7'h00, ready_irq_q});
    glb_ie = 1'b0;
    gap(3);
    check_byte("irq global off", 8'h00, {7'h00, ready_irq_q});
    $display("test interrupt done");
    i_cpu_io_model.ee_store(9'h1a5, 8'h00, `EE_MODE_ERASE);
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    expect_reg("mode kept", CTRL, 8'h12);
    i_cpu_io_model.ee_fetch(9'h1a5, v);
    check_byte("write survives reset", 8'hff, v);
    i_cpu_io_model.io_write(CTRL, 8'h20);
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    expect_reg("mode cleared", CTRL, 8'h00);
    $display("test reset done");
    summarize();
  end
endmodule : eeprom_access_controller_bench
`default_nettype wire
